// ===== design/ftvo_line_mem.sv
// Line memory holding one line of four-pixel beats, registered read port.
`timescale 1ns/1ps
module ftvo_line_mem (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [ftvo_pkg::FTVO_ADDR_W-1:0] wr_addr,
    input wire logic [ftvo_pkg::FTVO_TAPS*ftvo_pkg::FTVO_PIX_W-1:0] wr_data,
    input wire logic [ftvo_pkg::FTVO_ADDR_W-1:0] rd_addr,
    output logic [ftvo_pkg::FTVO_TAPS*ftvo_pkg::FTVO_PIX_W-1:0] rd_data
);
    import ftvo_pkg::*;

    logic [FTVO_TAPS*FTVO_PIX_W-1:0] mem_q [FTVO_MEM_DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= mem_q[rd_addr];
    end
endmodule : ftvo_line_mem

// ===== design/ftvo_pkg.sv
// Package of constants and types for the four-tap video output formatter.
package ftvo_pkg;
    // ************************************************************
    // Geometry and timing
    // ************************************************************
    localparam int FTVO_TAPS = 4;
    localparam int FTVO_PIX_W = 10;
    localparam int FTVO_OUT_W = 10;
    localparam int FTVO_NARROW_W = 8;
    localparam int FTVO_DROP_LSB = 2;
    localparam int FTVO_MAX_WIDTH = 2352;
    localparam int FTVO_MAX_LINES = 1726;
    localparam int FTVO_MAX_BEATS = FTVO_MAX_WIDTH / FTVO_TAPS;
    localparam int FTVO_BEAT_W = 10;
    localparam int FTVO_LINE_W = 11;
    localparam int FTVO_CNT_W = 10;
    localparam int FTVO_CLK_MHZ = 25;
    localparam int FTVO_LINE_DELAY_CLK = 24;
    localparam int FTVO_LINE_GAP_CLK = 8;
    localparam logic [FTVO_CNT_W-1:0] FTVO_DELAY_LAST = 10'(FTVO_LINE_DELAY_CLK - 1);
    localparam logic [FTVO_CNT_W-1:0] FTVO_GAP_LAST = 10'(FTVO_LINE_GAP_CLK - 1);
    localparam logic [FTVO_CNT_W-1:0] FTVO_CNT_ZERO = 10'h000;
    localparam logic [FTVO_LINE_W-1:0] FTVO_LINE_ZERO = 11'h000;
    localparam logic [FTVO_BEAT_W-1:0] FTVO_BEAT_ZERO = 10'h000;
    localparam logic [FTVO_LINE_W-1:0] FTVO_LINE_ONE = 11'h001;
    localparam logic [FTVO_BEAT_W-1:0] FTVO_BEAT_ONE = 10'h001;
    localparam logic [FTVO_BEAT_W-1:0] FTVO_BEAT_FULL = 10'(FTVO_MAX_BEATS);
    localparam logic [FTVO_LINE_W-1:0] FTVO_LINES_FULL = 11'(FTVO_MAX_LINES);
    localparam int FTVO_MEM_DEPTH = 1024;
    localparam int FTVO_ADDR_W = 10;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [4:0] {
        FTVO_IDLE  = 5'h01,
        FTVO_DELAY = 5'h02,
        FTVO_LINE  = 5'h04,
        FTVO_GAP   = 5'h08,
        FTVO_FETCH = 5'h10
    } ftvo_state_t;
endpackage : ftvo_pkg

// ===== design/ftvo_video_out.sv
// Four-tap video output sequencer: frame and line valid timing, tap mapping, truncation.
//
// What this block does
// - Four taps plus frame and line valid each clock.
// - All outputs launched on the rising clock edge.
// - Taps valid only with both valids high.
// - Images up to 2352 by 1726 supported.
// - Pixel clock rate; taps span X only, four adjacent pixels of one line.
// - A full line lasts at most 588 beats.
// - Raster order, top left to bottom right.
// - Ten-bit passes all bits; eight-bit drops two.
// - Both valids low when no data flows.
// - New capture may overlap the previous transmission.
// - Line valid rises 24 clocks after frame valid.
// - Beat n carries pixels 4n+1 to 4n+4.
// - Eight-clock line valid gap inside frame.
// - Frame and line valid fall together.
// - Area of interest shortens lines and frames.
`timescale 1ns/1ps
module ftvo_video_out (
    input wire logic clock,
    input wire logic resetn,
    input wire logic frame_start,
    input wire logic [ftvo_pkg::FTVO_BEAT_W-1:0] aoi_beats,
    input wire logic [ftvo_pkg::FTVO_LINE_W-1:0] aoi_lines,
    input wire logic mode_8bit,
    output logic line_request,
    output logic [ftvo_pkg::FTVO_LINE_W-1:0] line_index,
    input wire logic line_ready,
    input wire logic pix_valid,
    input wire logic [ftvo_pkg::FTVO_BEAT_W-1:0] pix_beat,
    input wire logic [ftvo_pkg::FTVO_TAPS*ftvo_pkg::FTVO_PIX_W-1:0] pix_data,
    output logic busy,
    output logic frame_valid,
    output logic line_valid,
    output logic [ftvo_pkg::FTVO_OUT_W-1:0] tap_stream_0,
    output logic [ftvo_pkg::FTVO_OUT_W-1:0] tap_stream_1,
    output logic [ftvo_pkg::FTVO_OUT_W-1:0] tap_stream_2,
    output logic [ftvo_pkg::FTVO_OUT_W-1:0] tap_stream_3
);
    import ftvo_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Clamps a requested size into 1..limit; zero selects the full size.
    function automatic logic [FTVO_LINE_W-1:0] clamp_size(
        input logic [FTVO_LINE_W-1:0] req,
        input logic [FTVO_LINE_W-1:0] limit
    );
        logic [FTVO_LINE_W-1:0] r;
        r = req;
        if (req == FTVO_LINE_ZERO || req > limit) begin
            r = limit;
        end
        return r;
    endfunction : clamp_size

    // Formats one pixel: full ten bits, or upper eight bits right aligned.
    function automatic logic [FTVO_OUT_W-1:0] fmt_pixel(
        input logic [FTVO_PIX_W-1:0] pix,
        input logic narrow
    );
        logic [FTVO_OUT_W-1:0] r;
        r = pix;
        if (narrow) begin
            r = {{FTVO_DROP_LSB{1'b0}}, pix[FTVO_PIX_W-1 -: FTVO_NARROW_W]};
        end
        return r;
    endfunction : fmt_pixel

    // True on the count value that ends a span of the given length.
    function automatic logic count_done(
        input logic [FTVO_CNT_W-1:0] cnt,
        input logic [FTVO_CNT_W-1:0] last
    );
        return cnt == last - 10'h001;
    endfunction : count_done

    // ************************************************************
    // State
    // ************************************************************
    ftvo_state_t state_q, state_d;
    logic [FTVO_CNT_W-1:0] cnt_q, cnt_d;
    logic [FTVO_BEAT_W-1:0] beat_q, beat_d;
    logic [FTVO_LINE_W-1:0] line_q, line_d;
    logic [FTVO_BEAT_W-1:0] beats_q, beats_d;
    logic [FTVO_LINE_W-1:0] lines_q, lines_d;
    logic narrow_q, narrow_d;
    logic fv_q, fv_d;
    logic lv_q, lv_d;
    logic [FTVO_OUT_W-1:0] tap_q [FTVO_TAPS];
    logic [FTVO_TAPS*FTVO_PIX_W-1:0] rd_data;
    logic [FTVO_ADDR_W-1:0] rd_addr;
    logic last_beat;
    logic last_line;
    logic wr_en;
    logic delay_done;
    logic gap_done;
    logic [FTVO_BEAT_W-1:0] beats_sel;
    logic [FTVO_LINE_W-1:0] lines_sel;

    // ************************************************************
    // Decoding
    // ************************************************************
    assign last_beat = (beat_q == beats_q - FTVO_BEAT_ONE);
    assign last_line = (line_q == lines_q - FTVO_LINE_ONE);
    assign delay_done = count_done(cnt_q, FTVO_DELAY_LAST);
    assign gap_done = count_done(cnt_q, FTVO_GAP_LAST);
    // Zero or an oversize request selects the full frame geometry.
    assign beats_sel = 10'(clamp_size(11'(aoi_beats), 11'(FTVO_BEAT_FULL)));
    assign lines_sel = clamp_size(aoi_lines, FTVO_LINES_FULL);
    // Line storage lets capture of the next frame run while this one is sent.
    assign wr_en = pix_valid;
    // The read runs one beat ahead of the beat being launched, so that beat's data
    // already sits in the read register on the cycle that launches it.
    assign rd_addr = lv_d ? beat_d + FTVO_BEAT_ONE : FTVO_BEAT_ZERO;
    assign busy = fv_q;
    assign line_request = (state_q == FTVO_FETCH);
    assign line_index = line_q;

    ftvo_line_mem u_mem (
        .clock(clock),
        .wr_en(wr_en),
        .wr_addr(pix_beat),
        .wr_data(pix_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        beat_d = beat_q;
        line_d = line_q;
        beats_d = beats_q;
        lines_d = lines_q;
        narrow_d = narrow_q;
        fv_d = fv_q;
        lv_d = 1'b0;
        case (state_q)
            FTVO_IDLE: begin
                fv_d = 1'b0;
                if (frame_start) begin
                    // Mode and size latch only here, at the frame boundary.
                    narrow_d = mode_8bit;
                    beats_d = beats_sel;
                    lines_d = lines_sel;
                    line_d = FTVO_LINE_ZERO;
                    cnt_d = FTVO_CNT_ZERO;
                    fv_d = 1'b1;
                    state_d = FTVO_DELAY;
                end
            end
            FTVO_DELAY: begin
                // Count from the frame-valid rise so line valid rises 24 clocks later.
                if (delay_done) begin
                    state_d = FTVO_FETCH;
                end else begin
                    cnt_d = cnt_q + 10'h001;
                end
            end
            FTVO_FETCH: begin
                if (line_ready) begin
                    beat_d = FTVO_BEAT_ZERO;
                    lv_d = 1'b1;
                    state_d = FTVO_LINE;
                end
            end
            FTVO_LINE: begin
                if (last_beat) begin
                    cnt_d = FTVO_CNT_ZERO;
                    if (last_line) begin
                        fv_d = 1'b0;
                        state_d = FTVO_IDLE;
                    end else begin
                        line_d = line_q + FTVO_LINE_ONE;
                        state_d = FTVO_GAP;
                    end
                end else begin
                    beat_d = beat_q + FTVO_BEAT_ONE;
                    lv_d = 1'b1;
                end
            end
            FTVO_GAP: begin
                // Frame valid stays high through the inter-line gap.
                if (gap_done) begin
                    state_d = FTVO_FETCH;
                end else begin
                    cnt_d = cnt_q + 10'h001;
                end
            end
            default: begin
                state_d = FTVO_IDLE;
                fv_d = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= FTVO_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= FTVO_CNT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            beat_q <= FTVO_BEAT_ZERO;
        end else begin
            beat_q <= beat_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            line_q <= FTVO_LINE_ZERO;
        end else begin
            line_q <= line_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            beats_q <= FTVO_BEAT_FULL;
        end else begin
            beats_q <= beats_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lines_q <= FTVO_LINES_FULL;
        end else begin
            lines_q <= lines_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            narrow_q <= 1'b0;
        end else begin
            narrow_q <= narrow_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fv_q <= 1'b0;
        end else begin
            fv_q <= fv_d;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lv_q <= 1'b0;
        end else begin
            lv_q <= lv_d;
        end
    end

    // ************************************************************
    // Tap formatting
    // ************************************************************
    // Tap k carries pixel 4n+k+1; taps are zero outside valid beats.
    for (genvar k = 0; k < FTVO_TAPS; k++) begin : g_tap
        logic [FTVO_OUT_W-1:0] tap_d;
        logic [FTVO_PIX_W-1:0] pix_k;
        assign pix_k = rd_data[k*FTVO_PIX_W +: FTVO_PIX_W];
        assign tap_d = lv_d ? fmt_pixel(pix_k, narrow_q) : {FTVO_OUT_W{1'b0}};
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                tap_q[k] <= {FTVO_OUT_W{1'b0}};
            end else begin
                tap_q[k] <= tap_d;
            end
        end
    end

    assign frame_valid = fv_q;
    assign line_valid = lv_q;
    assign tap_stream_0 = tap_q[0];
    assign tap_stream_1 = tap_q[1];
    assign tap_stream_2 = tap_q[2];
    assign tap_stream_3 = tap_q[3];
endmodule : ftvo_video_out

// ===== verif/ftvo_checker.sv
// Concurrent assertions on the ports of the four-tap video output formatter.
`timescale 1ns/1ps
module ftvo_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic frame_start,
    input wire logic mode_8bit,
    input wire logic line_ready,
    input wire logic busy,
    input wire logic frame_valid,
    input wire logic line_valid,
    input wire logic [ftvo_pkg::FTVO_OUT_W-1:0] tap_stream_0,
    input wire logic [ftvo_pkg::FTVO_OUT_W-1:0] tap_stream_1,
    input wire logic [ftvo_pkg::FTVO_OUT_W-1:0] tap_stream_2,
    input wire logic [ftvo_pkg::FTVO_OUT_W-1:0] tap_stream_3
);
    import ftvo_pkg::*;
    logic narrow_q;
    logic [10:0] run_q;
    logic [9:0] since_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            narrow_q <= 1'b0;
            run_q <= 11'h000;
            since_q <= 10'h000;
        end else begin
            if (frame_start && !frame_valid) narrow_q <= mode_8bit;
            run_q <= line_valid ? run_q + 11'h001 : 11'h000;
            since_q <= !frame_valid ? 10'h000 : (since_q == 10'h3FF ? since_q : since_q + 10'h001);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_start_delay: assert property ($rose(frame_valid) |->
        ##24 (line_valid || !$past(line_ready)))
        else $error("line valid late after frame valid");
    a_no_early: assert property (line_valid |-> since_q >= 10'h018)
        else $error("line valid too early");
    a_gap_eight: assert property ($fell(line_valid) && frame_valid |->
        (!line_valid)[*8] ##1 (line_valid || !$past(line_ready)))
        else $error("line gap not eight clocks");
    a_valid_nest: assert property (line_valid |-> frame_valid)
        else $error("line valid outside frame");
    a_fall_together: assert property ($fell(frame_valid) |-> $fell(line_valid))
        else $error("frame end without line end");
    a_taps_idle: assert property (!line_valid |->
        (tap_stream_0 | tap_stream_1 | tap_stream_2 | tap_stream_3) == 10'h000)
        else $error("taps not zero outside line");
    a_narrow_top: assert property (line_valid && narrow_q |->
        {tap_stream_0[9:8], tap_stream_1[9:8], tap_stream_2[9:8], tap_stream_3[9:8]} == 8'h00)
        else $error("narrow mode top bits set");
    a_busy_equal: assert property (busy == frame_valid)
        else $error("busy differs from frame valid");
    a_start_taken: assert property (frame_start && !frame_valid |=> frame_valid)
        else $error("frame start not taken");
    a_line_max: assert property (line_valid |-> run_q < 11'h24C)
        else $error("line longer than 588 beats");
endmodule : ftvo_checker

bind ftvo_video_out ftvo_checker u_chk (.clock(clock), .resetn(resetn),
    .frame_start(frame_start), .mode_8bit(mode_8bit), .line_ready(line_ready), .busy(busy),
    .frame_valid(frame_valid), .line_valid(line_valid), .tap_stream_0(tap_stream_0),
    .tap_stream_1(tap_stream_1), .tap_stream_2(tap_stream_2), .tap_stream_3(tap_stream_3));

// ===== verif/ftvo_source_model.sv
// Pixel source that fills the line memory one line at a time, promptly or slowly.
`timescale 1ns/1ps
module ftvo_source_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic frame_valid,
    input wire logic line_valid,
    input wire logic slow,
    input wire logic [ftvo_pkg::FTVO_BEAT_W-1:0] aoi_beats,
    output logic line_ready,
    output logic pix_valid,
    output logic [ftvo_pkg::FTVO_BEAT_W-1:0] pix_beat,
    output logic [ftvo_pkg::FTVO_TAPS*ftvo_pkg::FTVO_PIX_W-1:0] pix_data
);
    import ftvo_pkg::*;
    logic fv_q, lv_q, fill_q;
    int line_n, wait_n, beat_n, nb;
    always_comb nb = (aoi_beats == 10'h000 || aoi_beats > 10'h24C) ? 588 : int'(aoi_beats);
    // The next line is written only after the previous one has been read out.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {fv_q, lv_q, fill_q, line_ready, pix_valid} <= 5'h00;
            pix_beat <= '0;
            pix_data <= '0;
            {line_n, wait_n, beat_n} <= '0;
        end else begin
            fv_q <= frame_valid;
            lv_q <= line_valid;
            pix_valid <= 1'b0;
            pix_data <= ~pix_data;
            if (line_valid && !lv_q) line_ready <= 1'b0;
            if ((frame_valid && !fv_q) || (!line_valid && lv_q && frame_valid)) begin
                line_n <= (frame_valid && !fv_q) ? 0 : line_n + 1;
                fill_q <= 1'b1;
                beat_n <= 0;
                wait_n <= slow ? 20 : 0;
            end else if (fill_q && wait_n > 0) begin
                wait_n <= wait_n - 1;
            end else if (fill_q && beat_n < nb) begin
                pix_valid <= 1'b1;
                pix_beat <= 10'(beat_n);
                for (int k = 0; k < 4; k++) begin
                    pix_data[k*10+:10] <= 10'(line_n*7 + (beat_n*4+k)*3 + 1);
                end
                beat_n <= beat_n + 1;
            end else if (fill_q) begin
                fill_q <= 1'b0;
                line_ready <= 1'b1;
            end
        end
    end
endmodule : ftvo_source_model

// ===== verif/ftvo_video_out_tb.sv
// Self-checking testbench for the four-tap video output formatter.
`timescale 1ns/1ps
module ftvo_video_out_tb;
    import ftvo_pkg::*;
    logic clock, resetn, frame_start, mode_8bit, line_request, line_ready, pix_valid, slow;
    logic busy, frame_valid, line_valid;
    logic [FTVO_BEAT_W-1:0] aoi_beats, pix_beat;
    logic [FTVO_LINE_W-1:0] aoi_lines, line_index;
    logic [39:0] pix_data;
    logic [FTVO_OUT_W-1:0] tap_stream_0, tap_stream_1, tap_stream_2, tap_stream_3;
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    ftvo_video_out dut (.clock(clock), .resetn(resetn), .frame_start(frame_start),
        .aoi_beats(aoi_beats), .aoi_lines(aoi_lines), .mode_8bit(mode_8bit),
        .line_request(line_request), .line_index(line_index), .line_ready(line_ready),
        .pix_valid(pix_valid), .pix_beat(pix_beat), .pix_data(pix_data), .busy(busy),
        .frame_valid(frame_valid), .line_valid(line_valid), .tap_stream_0(tap_stream_0),
        .tap_stream_1(tap_stream_1), .tap_stream_2(tap_stream_2), .tap_stream_3(tap_stream_3));
    ftvo_source_model src (.clock(clock), .resetn(resetn), .frame_valid(frame_valid),
        .line_valid(line_valid), .slow(slow), .aoi_beats(aoi_beats), .line_ready(line_ready),
        .pix_valid(pix_valid), .pix_beat(pix_beat), .pix_data(pix_data));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : check
    function automatic logic [9:0] expv(input int l, input int p, input logic m8);
        logic [9:0] v;
        v = 10'(l * 7 + p * 3 + 1);
        return m8 ? {2'b00, v[9:2]} : v;
    endfunction : expv
    // Sends one frame, flips mode and pulses start mid-frame, and checks every beat.
    task automatic run_frame(input int nb, input int nl, input logic m8, input logic sl);
        int t, g, nbf;
        logic [39:0] want, got;
        nbf = (nb == 0 || nb > 588) ? 588 : nb;
        slow = sl;
        aoi_beats = 10'(nb);
        aoi_lines = 11'(nl);
        mode_8bit = m8;
        frame_start = 1'b1;
        @(negedge clock);
        frame_start = 1'b0;
        mode_8bit = ~m8;
        check(frame_valid === 1'b1 && busy === 1'b1, "frame start");
        t = 0;
        while (line_valid !== 1'b1 && t < 2000) begin
            @(negedge clock);
            t++;
            frame_start = (t == 3);
            if (t == 23) begin
                check(line_request === 1'b1 && line_index === 11'h000, "request");
            end
        end
        if (!sl) check(t == ((nbf > 21) ? nbf + 3 : 24), "first line delay");
        for (int l = 0; l < nl; l++) begin
            for (int b = 0; b < nbf; b++) begin
                want = {expv(l, 4*b+3, m8), expv(l, 4*b+2, m8),
                        expv(l, 4*b+1, m8), expv(l, 4*b, m8)};
                got = {tap_stream_3, tap_stream_2, tap_stream_1, tap_stream_0};
                check(got === want, "beat");
                check(line_valid === 1'b1 && frame_valid === 1'b1, "valid");
                check(line_index === 11'(l), "line index");
                @(negedge clock);
            end
            check(line_valid === 1'b0, "line length");
            if (l == nl - 1) check(frame_valid === 1'b0, "frame end");
            g = 0;
            while (l < nl - 1 && line_valid !== 1'b1 && g < 2000) begin
                @(negedge clock);
                g++;
            end
            if (l < nl - 1) begin
                check(sl ? g >= 8 : g == ((nbf > 5) ? nbf + 3 : 8), "line gap");
            end
        end
        repeat (30) begin
            @(negedge clock);
            check(frame_valid === 1'b0 && line_valid === 1'b0, "idle");
            check(line_request === 1'b0, "no request");
        end
    endtask : run_frame
    task automatic s_ten_bit;
        run_frame(4, 3, 1'b0, 1'b0);
    endtask : s_ten_bit
    task automatic s_eight_bit;
        run_frame(3, 2, 1'b1, 1'b0);
    endtask : s_eight_bit
    task automatic s_slow_source;
        run_frame(5, 2, 1'b0, 1'b1);
    endtask : s_slow_source
    task automatic s_full_width;
        run_frame(700, 2, 1'b1, 1'b0);
    endtask : s_full_width
    task automatic report_and_stop;
        $display("errors %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        {resetn, frame_start, mode_8bit, slow} = 4'h0;
        aoi_beats = 10'h004;
        aoi_lines = 11'h001;
        repeat (16) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        s_ten_bit();
        s_eight_bit();
        s_slow_source();
        s_full_width();
        report_and_stop();
    end
endmodule : ftvo_video_out_tb
